/* bench/tb_uesev_top.sv */
// Purpose: Self-checking bench for the severity register block.
// Assumes: Inputs change at falling edges; one access every two cycles.
// Notes: Random writes and error traffic from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb_uesev_top;
  import uesev_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic link_reset_in = 1'b0;
  logic global_reset_in = 1'b0;
  logic cfg_req_in = 1'b0;
  logic cfg_write_in = 1'b0;
  uesev_addr_t cfg_addr_in = '0;
  logic [31:0] cfg_wdata_in = '0;
  logic [3:0] cfg_be_in = '0;
  uesev_class_vec_t error_event_in = '0;
  uesev_class_vec_t error_mask_in = '0;
  logic cfg_ready_out, cfg_ack_out, cfg_hit_out, fatal_msg_out, nonfatal_msg_out, fundamental_reset_n_out;
  logic [31:0] cfg_rdata_out, exp_reg, rd, wd, rnd;
  logic [3:0] be;
  logic hit;
  uesev_class_vec_t class_severity_out, live;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 51;
  always #10 clock_in = ~clock_in;
  uesev_top dut_u (.clock_in, .resetn_in, .link_reset_in, .global_reset_in, .cfg_req_in, .cfg_write_in,
    .cfg_addr_in, .cfg_wdata_in, .cfg_be_in, .cfg_ready_out, .cfg_ack_out, .cfg_hit_out, .cfg_rdata_out,
    .error_event_in, .error_mask_in, .class_severity_out, .fatal_msg_out, .nonfatal_msg_out,
    .fundamental_reset_n_out);
  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] wr_model(input logic [31:0] old, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h001F_F010;
    return (old & ~m) | (d & m);
  endfunction
  function automatic uesev_class_vec_t sev_of(input logic [31:0] r);
    return {r[20:12], r[4]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic w, input uesev_addr_t a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clock_in);
    cfg_req_in = 1'b1;
    cfg_write_in = w;
    cfg_addr_in = a;
    cfg_wdata_in = d;
    cfg_be_in = b;
    @(negedge clock_in);
    cfg_req_in = 1'b0;
    chk(cfg_ack_out, 1'b1);
    chk(cfg_ready_out, 1'b0);
    rd = cfg_rdata_out;
    hit = cfg_hit_out;
  endtask
  task automatic rd_chk();
    access(1'b0, 12'h10C, 32'h0, 4'h0);
    chk(hit, 1'b1);
    chk(rd, exp_reg);
    chk(class_severity_out, sev_of(exp_reg));
  endtask
  // Which: 0 link pin, 1 global pin, 2 lesser reset
  task automatic pin_reset(input int which);
    @(negedge clock_in);
    if (which == 0) link_reset_in = 1'b0;
    else if (which == 1) global_reset_in = 1'b0;
    else resetn_in = 1'b0;
    #1;
    chk(fundamental_reset_n_out, which == 2);
    repeat (2) @(negedge clock_in);
    link_reset_in = 1'b1;
    global_reset_in = 1'b1;
    resetn_in = 1'b1;
    for (int i = 0; i < 20 && fundamental_reset_n_out !== 1'b1; i++) @(negedge clock_in);
    chk(fundamental_reset_n_out, 1'b1);
    // Fixed ones at bits 5 and 0 read back on top of the reset word
    if (which != 2) exp_reg = 32'h0006_2011 | 32'h0000_0021;
    rd_chk();
  endtask
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    @(negedge clock_in);
    pin_reset(0);
    chk(class_severity_out[9], 1'b0);
    chk(class_severity_out[8], 1'b0);
    chk(class_severity_out[2], 1'b1);
    chk(class_severity_out[0], 1'b1);
    // Corners first: all ones, all zeros, then random lanes
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      wd = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : rnd;
      rnd = $random(seed);
      be = (i < 2) ? 4'hF : rnd[3:0];
      access(1'b1, 12'h10C, wd, be);
      chk(hit, 1'b1);
      chk(rd, 32'h0);
      exp_reg = wr_model(exp_reg, wd, be);
      rd_chk();
    end
    access(1'b1, 12'h108, 32'hFFFF_FFFF, 4'hF);
    chk(hit, 1'b0);
    chk(rd, 32'h0);
    rd_chk();
    live = '0;
    for (int i = 0; i < 41; i++) begin
      @(negedge clock_in);
      chk(fatal_msg_out, |(live & sev_of(exp_reg)));
      chk(nonfatal_msg_out, |(live & ~sev_of(exp_reg)));
      rnd = $random(seed);
      error_event_in = (i < 40) ? rnd[9:0] : '0;
      error_mask_in = (i < 5) ? '0 : rnd[19:10];
      live = error_event_in & ~error_mask_in;
    end
    // Lesser reset first, so the ones written must survive it
    for (int k = 2; k >= 0; k--) begin
      access(1'b1, 12'h10C, 32'hFFFF_FFFF, 4'hF);
      exp_reg = wr_model(exp_reg, 32'hFFFF_FFFF, 4'hF);
      pin_reset(k);
    end
    test_done();
  end
endmodule
`default_nettype wire

/* bench/uesev_top_props.sv */
// Purpose: Port-level assertions for the severity register block.
// Assumes: Bound to uesev_top; answers and messages are registered.
// Notes: Severity index 0 is bit 4, indices 1 to 9 are bits 12 to 20.
`timescale 1ns/1ps
`default_nettype none
module uesev_top_props (
  // Clock and resets
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic link_reset_in,
  input wire logic global_reset_in,
  input wire logic fundamental_reset_n_out,
  // Configuration access
  input wire logic cfg_req_in,
  input wire logic cfg_write_in,
  input wire logic cfg_ready_out,
  input wire logic cfg_ack_out,
  input wire logic cfg_hit_out,
  input wire logic [31:0] cfg_rdata_out,
  // Error path
  input wire uesev_pkg::uesev_class_vec_t error_event_in,
  input wire uesev_pkg::uesev_class_vec_t error_mask_in,
  input wire uesev_pkg::uesev_class_vec_t class_severity_out,
  input wire logic fatal_msg_out,
  input wire logic nonfatal_msg_out
);
  import uesev_pkg::*;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  uesev_class_vec_t live;
  assign live = error_event_in & ~error_mask_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in || !fundamental_reset_n_out);
  a_ack_one_pulse: assert property (
    cfg_req_in && cfg_ready_out |=> cfg_ack_out && !cfg_ready_out ##1 !cfg_ack_out && cfg_ready_out)
    else $error("access answer pulse wrong");
  a_reserved_read_fixed: assert property (
    cfg_ack_out && cfg_hit_out && cfg_rdata_out != 32'h0 |-> (cfg_rdata_out & 32'hFFE0_0FEF) == 32'h0000_0021)
    else $error("reserved bits read wrong");
  a_read_shows_sev: assert property (
    cfg_ack_out && cfg_hit_out && cfg_rdata_out != 32'h0 |-> {cfg_rdata_out[20:12], cfg_rdata_out[4]} == class_severity_out)
    else $error("read data differs from severity");
  a_miss_reads_zero: assert property (
    cfg_ack_out && !cfg_hit_out |-> cfg_rdata_out == 32'h0)
    else $error("miss returned data");
  a_fatal_when_set: assert property (
    |(live & class_severity_out) |=> fatal_msg_out)
    else $error("fatal message missing");
  a_nonfatal_when_clear: assert property (
    |(live & ~class_severity_out) |=> nonfatal_msg_out)
    else $error("nonfatal message missing");
  a_masked_silent: assert property (
    live == '0 |=> !fatal_msg_out && !nonfatal_msg_out)
    else $error("message without unmasked event");
  a_sev_keeps_value: assert property (
    disable iff (!fundamental_reset_n_out) !(cfg_req_in && cfg_write_in) |=> $stable(class_severity_out))
    else $error("severity changed without write");
  a_pin_forces_reset: assert property (
    disable iff (!resetn_in) !link_reset_in || !global_reset_in |-> !fundamental_reset_n_out)
    else $error("fundamental reset not asserted");
  a_reset_defaults: assert property (
    disable iff (!resetn_in) $rose(fundamental_reset_n_out) |-> class_severity_out == 10'h0C5)
    else $error("severity default wrong");
endmodule
bind uesev_top uesev_top_props u_props (.clock_in, .resetn_in, .link_reset_in, .global_reset_in,
  .fundamental_reset_n_out, .cfg_req_in, .cfg_write_in, .cfg_ready_out, .cfg_ack_out, .cfg_hit_out,
  .cfg_rdata_out, .error_event_in, .error_mask_in, .class_severity_out, .fatal_msg_out, .nonfatal_msg_out);
`default_nettype wire

/* common/uesev_params.svh */
// Purpose: Constants for the uncorrectable error severity register block.
// Assumes: Included by the package and by the uesev_top module.
// Notes: Definitions only.
`ifndef UESEV_PARAMS_SVH
`define UESEV_PARAMS_SVH

// ----------------------------------------------------------------------
// Register placement
// ----------------------------------------------------------------------
`define UESEV_REG_OFFSET 12'h10C
`define UESEV_ADDR_WIDTH 12

// ----------------------------------------------------------------------
// Register contents
// ----------------------------------------------------------------------
`define UESEV_RESET_VALUE 32'h0006_2011
`define UESEV_WRITE_MASK 32'h001F_F010
`define UESEV_FIXED_ONES 32'h0000_0021
`define UESEV_READ_NONE 32'h0000_0000

// ----------------------------------------------------------------------
// Severity bit positions
// ----------------------------------------------------------------------
`define UESEV_BIT_UNSUPPORTED_REQUEST 20
`define UESEV_BIT_END_TO_END_CRC 19
`define UESEV_BIT_MALFORMED_PACKET 18
`define UESEV_BIT_RECEIVE_CREDIT_OVERFLOW 17
`define UESEV_BIT_UNEXPECTED_COMPLETION 16
`define UESEV_BIT_COMPLETER_ABORT 15
`define UESEV_BIT_COMPLETION_TIMEOUT 14
`define UESEV_BIT_FLOW_CONTROL 13
`define UESEV_BIT_POISONED_PACKET 12
`define UESEV_BIT_LINK_PROTOCOL 4

// ----------------------------------------------------------------------
// Error classes
// ----------------------------------------------------------------------
`define UESEV_NUM_CLASSES 10

`endif

/* common/uesev_pkg.sv */
// Purpose: Types shared by the uncorrectable error severity block.
// Assumes: uesev_params.svh on the include path.
// Notes: Numbers live in the header; this package holds types only.
`include "uesev_params.svh"

package uesev_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef logic [`UESEV_NUM_CLASSES-1:0] uesev_class_vec_t;
  typedef logic [`UESEV_ADDR_WIDTH-1:0] uesev_addr_t;

  typedef enum logic [3:0] {
    UESEV_CLS_LINK_PROTOCOL = 4'h0,
    UESEV_CLS_POISONED_PACKET = 4'h1,
    UESEV_CLS_FLOW_CONTROL = 4'h2,
    UESEV_CLS_COMPLETION_TIMEOUT = 4'h3,
    UESEV_CLS_COMPLETER_ABORT = 4'h4,
    UESEV_CLS_UNEXPECTED_COMPLETION = 4'h5,
    UESEV_CLS_RECEIVE_CREDIT_OVERFLOW = 4'h6,
    UESEV_CLS_MALFORMED_PACKET = 4'h7,
    UESEV_CLS_END_TO_END_CRC = 4'h8,
    UESEV_CLS_UNSUPPORTED_REQUEST = 4'h9
  } uesev_class_t;

  typedef enum logic [0:0] {
    UESEV_IDLE = 1'b0,
    UESEV_RESPOND = 1'b1
  } uesev_state_t;

endpackage

/* src/uesev_reset_gen.sv */
// Purpose: Builds the fundamental reset from the link and global resets.
// Assumes: Both reset pins are active low and asynchronous to clock_in.
// Notes: Assertion is immediate, release is synchronised to clock_in.
`timescale 1ns/1ps
`default_nettype none

module uesev_reset_gen (
  // Clock
  input wire logic clock_in,
  // Reset pins, active low
  input wire logic link_reset_in,
  input wire logic global_reset_in,
  // Fundamental reset, active low
  output logic fundamental_reset_n_out
);

  // --------------------------------------------------------------------
  // Combined request
  // --------------------------------------------------------------------
  logic raw_reset_n;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  // Either pin low forces the fundamental reset at once
  assign raw_reset_n = link_reset_in & global_reset_in;

  // --------------------------------------------------------------------
  // Release synchroniser
  // --------------------------------------------------------------------
  // Release is only trusted once stages two and three agree
  always_ff @(posedge clock_in or negedge raw_reset_n) begin
    if (!raw_reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge clock_in or negedge raw_reset_n) begin
    if (!raw_reset_n) begin
      fundamental_reset_n_out <= 1'b0;
    end else begin
      fundamental_reset_n_out <= sync2_r & sync3_r;
    end
  end

endmodule

`default_nettype wire

/* src/uesev_top.sv */
// Purpose: Uncorrectable error severity register with severity routing.
// Assumes: Configuration accesses and error events come from clock_in logic.
// Notes: One request is served at a time; answer one cycle after it is taken.
`timescale 1ns/1ps
`default_nettype none

`include "uesev_params.svh"

module uesev_top (
  // Clock and lesser reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Reset pins, active low, feeding the fundamental reset
  input wire logic link_reset_in,
  input wire logic global_reset_in,
  // Configuration access
  input wire logic cfg_req_in,
  input wire logic cfg_write_in,
  input wire uesev_pkg::uesev_addr_t cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [3:0] cfg_be_in,
  output logic cfg_ready_out,
  output logic cfg_ack_out,
  output logic cfg_hit_out,
  output logic [31:0] cfg_rdata_out,
  // Error events and masks, one bit per class
  input wire uesev_pkg::uesev_class_vec_t error_event_in,
  input wire uesev_pkg::uesev_class_vec_t error_mask_in,
  // Severity and message requests
  output uesev_pkg::uesev_class_vec_t class_severity_out,
  output logic fatal_msg_out,
  output logic nonfatal_msg_out,
  // Reset status
  output logic fundamental_reset_n_out
);

  import uesev_pkg::*;

  // --------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------
  localparam logic [31:0] WR_MASK = `UESEV_WRITE_MASK;
  localparam logic [31:0] FIXED_ONES = `UESEV_FIXED_ONES;
  localparam logic [31:0] RESET_VALUE = `UESEV_RESET_VALUE;
  localparam uesev_addr_t REG_OFFSET = `UESEV_REG_OFFSET;
  localparam int NUM_CLASSES = `UESEV_NUM_CLASSES;

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  // Register bit that carries the severity of a class
  function automatic int class_bit(input int cls);
    case (cls)
      UESEV_CLS_LINK_PROTOCOL: return `UESEV_BIT_LINK_PROTOCOL;
      UESEV_CLS_POISONED_PACKET: return `UESEV_BIT_POISONED_PACKET;
      UESEV_CLS_FLOW_CONTROL: return `UESEV_BIT_FLOW_CONTROL;
      UESEV_CLS_COMPLETION_TIMEOUT: return `UESEV_BIT_COMPLETION_TIMEOUT;
      UESEV_CLS_COMPLETER_ABORT: return `UESEV_BIT_COMPLETER_ABORT;
      UESEV_CLS_UNEXPECTED_COMPLETION: return `UESEV_BIT_UNEXPECTED_COMPLETION;
      UESEV_CLS_RECEIVE_CREDIT_OVERFLOW: return `UESEV_BIT_RECEIVE_CREDIT_OVERFLOW;
      UESEV_CLS_MALFORMED_PACKET: return `UESEV_BIT_MALFORMED_PACKET;
      UESEV_CLS_END_TO_END_CRC: return `UESEV_BIT_END_TO_END_CRC;
      UESEV_CLS_UNSUPPORTED_REQUEST: return `UESEV_BIT_UNSUPPORTED_REQUEST;
      default: return `UESEV_BIT_LINK_PROTOCOL;
    endcase
  endfunction

  // Dword match; low address bits are ignored
  function automatic logic reg_hit(input uesev_addr_t addr);
    return addr[`UESEV_ADDR_WIDTH-1:2] == REG_OFFSET[`UESEV_ADDR_WIDTH-1:2];
  endfunction

  // --------------------------------------------------------------------
  // Fundamental reset
  // --------------------------------------------------------------------
  logic fundamental_reset_n;
  logic core_reset_n;

  uesev_reset_gen u_reset_gen (
    .clock_in(clock_in),
    .link_reset_in(link_reset_in),
    .global_reset_in(global_reset_in),
    .fundamental_reset_n_out(fundamental_reset_n)
  );

  assign fundamental_reset_n_out = fundamental_reset_n;

  // Access and message state also fall with the fundamental reset
  assign core_reset_n = resetn_in & fundamental_reset_n;

  // --------------------------------------------------------------------
  // Access control
  // --------------------------------------------------------------------
  uesev_state_t state_r;
  uesev_state_t state_nxt;
  logic take;
  logic write_now;

  assign take = cfg_req_in & (state_r == UESEV_IDLE);
  assign write_now = take & cfg_write_in & reg_hit(cfg_addr_in);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      UESEV_IDLE: begin
        if (cfg_req_in) begin
          state_nxt = UESEV_RESPOND;
        end
      end
      UESEV_RESPOND: begin
        state_nxt = UESEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge core_reset_n) begin
    if (!core_reset_n) begin
      state_r <= UESEV_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge core_reset_n) begin
    if (!core_reset_n) begin
      cfg_ready_out <= 1'b1;
    end else begin
      cfg_ready_out <= (state_nxt == UESEV_IDLE);
    end
  end

  // --------------------------------------------------------------------
  // Severity storage
  // --------------------------------------------------------------------
  logic [31:0] reg_value;

  // Writable bits sit on the fundamental reset only, so a lesser reset
  // leaves software's severity choices in place
  for (genvar b = 0; b < 32; b++) begin : g_bit
    if (WR_MASK[b]) begin : g_rw
      logic sev_r;
      always_ff @(posedge clock_in or negedge fundamental_reset_n) begin
        if (!fundamental_reset_n) begin
          sev_r <= RESET_VALUE[b];
        end else if (write_now && cfg_be_in[b/8]) begin
          sev_r <= cfg_wdata_in[b];
        end
      end
      assign reg_value[b] = sev_r;
    end else begin : g_ro
      // Fixed bits ignore writes
      assign reg_value[b] = FIXED_ONES[b];
    end
  end

  // --------------------------------------------------------------------
  // Read answer
  // --------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge core_reset_n) begin
    if (!core_reset_n) begin
      cfg_ack_out <= 1'b0;
      cfg_hit_out <= 1'b0;
      cfg_rdata_out <= `UESEV_READ_NONE;
    end else begin
      cfg_ack_out <= take;
      if (take) begin
        cfg_hit_out <= reg_hit(cfg_addr_in);
        // Only a read that hits returns the register; writes and misses return zero
        if (!cfg_write_in && reg_hit(cfg_addr_in)) begin
          cfg_rdata_out <= reg_value;
        end else begin
          cfg_rdata_out <= `UESEV_READ_NONE;
        end
      end else begin
        cfg_hit_out <= 1'b0;
        cfg_rdata_out <= `UESEV_READ_NONE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Severity routing
  // --------------------------------------------------------------------
  uesev_class_vec_t class_sev;
  uesev_class_vec_t unmasked;

  for (genvar c = 0; c < NUM_CLASSES; c++) begin : g_class
    assign class_sev[c] = reg_value[class_bit(c)];
  end

  assign class_severity_out = class_sev;

  // A masked class never reaches either message
  assign unmasked = error_event_in & ~error_mask_in;

  // Events of both severities in one cycle raise both requests
  always_ff @(posedge clock_in or negedge core_reset_n) begin
    if (!core_reset_n) begin
      fatal_msg_out <= 1'b0;
      nonfatal_msg_out <= 1'b0;
    end else begin
      fatal_msg_out <= |(unmasked & class_sev);
      nonfatal_msg_out <= |(unmasked & ~class_sev);
    end
  end

endmodule

`default_nettype wire
